// File: design/lpts_stamper.sv
`timescale 1ns/10ps
`include "lpts_defs.svh"
`default_nettype none

// ----------------------------------------------------------------
// byte fifo
// ----------------------------------------------------------------
module lpts_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 32
) (
    // clock, reset and enable
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_reg;
    logic [AW:0]  wr_next;
    logic [AW:0]  rd_reg;
    logic [AW:0]  rd_next;
    logic         push;
    logic         pop;

    always_comb begin
        in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        out_valid = wr_reg != rd_reg;
        out_data  = mem[rd_reg[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_next   = wr_reg + (AW+1)'(push);
        rd_next   = rd_reg + (AW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (clk_en) begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            if (push) begin
                mem[wr_reg[AW-1:0]] <= in_data;
            end
        end
    end
endmodule : lpts_fifo

// ----------------------------------------------------------------
// time stamper and framer
// ----------------------------------------------------------------
module lpts_stamper #(
    parameter int          TICK_CYCLES = `LPTS_TICK_CYCLES,
    parameter int          LOST_CYCLES = `LPTS_TICK_CYCLES * 3 / 2,
    parameter int          FIFO_DEPTH  = 32,
    parameter logic [47:0] SRC_MAC     = 48'h02_00_00_00_00_01
) (
    // clock, reset, enable
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // gps receiver
    input  wire logic                 pps_pin,
    input  wire logic                 nmea_valid,
    input  wire lpts_pkg::lpts_dt_s   nmea_time,
    input  wire logic [7:0]           nmea_fix_status,
    // point-cloud control
    input  wire logic                 pc_req,
    input  wire lpts_pkg::lpts_ret_e  ret_mode,
    input  wire logic                 seq_enable,
    output logic                      pc_busy,
    output logic [7:0]                seq_flag_byte,
    // status
    output logic                      pps_locked,
    output logic                      tick_pulse,
    output lpts_pkg::lpts_dt_s        cur_time,
    // byte stream out
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output lpts_pkg::lpts_beat_s      out_beat
);
    localparam int CW = $clog2(LOST_CYCLES + 1);
    localparam int US_CYC = `LPTS_US_CYCLES;

    typedef enum logic [1:0] {ST_IDLE, ST_PC, ST_GPS} lpts_state_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] ret_code(input lpts_pkg::lpts_ret_e m);
        unique case (m)
            lpts_pkg::RET_FIRST:           ret_code = `LPTS_RM_FIRST;
            lpts_pkg::RET_STRONGEST:       ret_code = `LPTS_RM_STRONG;
            lpts_pkg::RET_LAST:            ret_code = `LPTS_RM_LAST;
            lpts_pkg::RET_LAST_STRONGEST:  ret_code = `LPTS_RM_LAST_STR;
            lpts_pkg::RET_LAST_FIRST:      ret_code = `LPTS_RM_LAST_FST;
            lpts_pkg::RET_FIRST_STRONGEST: ret_code = `LPTS_RM_FST_STR;
            default:                       ret_code = `LPTS_RM_FIRST;
        endcase
    endfunction : ret_code

    function automatic logic [7:0] month_days(input logic [7:0] y,
                                              input logic [7:0] m);
        // year is offset from 1900, which is a multiple of four
        if (m == 8'h02) begin
            month_days = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0b) begin
            month_days = 8'h1e;
        end else begin
            month_days = 8'h1f;
        end
    endfunction : month_days

    function automatic lpts_pkg::lpts_dt_s add_second(
            input lpts_pkg::lpts_dt_s t);
        lpts_pkg::lpts_dt_s r;
        r = t;
        if (t.second < 8'h3b) begin
            r.second = t.second + 8'h01;
        end else begin
            r.second = 8'h00;
            if (t.minute < 8'h3b) begin
                r.minute = t.minute + 8'h01;
            end else begin
                r.minute = 8'h00;
                if (t.hour < 8'h17) begin
                    r.hour = t.hour + 8'h01;
                end else begin
                    r.hour = 8'h00;
                    if (t.day < month_days(t.year, t.month)) begin
                        r.day = t.day + 8'h01;
                    end else begin
                        r.day = 8'h01;
                        if (t.month < 8'h0c) begin
                            r.month = t.month + 8'h01;
                        end else begin
                            r.month = 8'h01;
                            r.year  = t.year + 8'h01;
                        end
                    end
                end
            end
        end
        add_second = r;
    endfunction : add_second

    // ascii pair, lower (units) byte first on the wire
    function automatic logic [15:0] ascii_pair(input logic [7:0] v);
        logic [7:0] w;
        w = v % 8'd100;
        ascii_pair = {8'h30 + (w % 8'd10), 8'h30 + (w / 8'd10)};
    endfunction : ascii_pair

    // ------------------------------------------------------------
    // pps synchroniser and time base
    // ------------------------------------------------------------
    logic               pps_meta_reg;
    logic               pps_sync_reg;
    logic               pps_prev_reg;
    logic [CW-1:0]      cnt_reg,    cnt_next;
    logic               lock_reg,   lock_next;
    logic               have_reg,   have_next;
    lpts_pkg::lpts_dt_s nmea_reg,   nmea_next;
    lpts_pkg::lpts_dt_s time_reg,   time_next;
    logic [7:0]         us_div_reg, us_div_next;
    logic [19:0]        us_reg,     us_next;
    logic               tick;
    logic               pps_rise;

    always_comb begin
        pps_rise    = pps_sync_reg && !pps_prev_reg;
        cnt_next    = cnt_reg + CW'(1);
        lock_next   = lock_reg;
        tick        = 1'b0;
        if (pps_rise) begin
            tick      = 1'b1;
            lock_next = 1'b1;
        end else if (lock_reg && cnt_reg == CW'(LOST_CYCLES - 1)) begin
            tick      = 1'b1;
            lock_next = 1'b0;
        end else if (!lock_reg && cnt_reg >= CW'(TICK_CYCLES - 1)) begin
            tick      = 1'b1;
        end
        if (tick) begin
            cnt_next = '0;
        end
        // a sentence arriving on the tick edge is kept for the next tick
        have_next = nmea_valid || (have_reg && !tick);
        nmea_next = nmea_valid ? nmea_time : nmea_reg;
        time_next = time_reg;
        if (tick) begin
            if (pps_rise && have_reg) begin
                time_next = add_second(nmea_reg);
            end else begin
                time_next = add_second(time_reg);
            end
        end
        us_div_next = (us_div_reg == 8'(US_CYC - 1)) ? 8'h00
                                                     : us_div_reg + 8'h01;
        us_next = us_reg;
        if (us_div_reg == 8'(US_CYC - 1) && us_reg < `LPTS_US_MAX) begin
            us_next = us_reg + 20'h1;
        end
        if (tick) begin
            us_div_next = 8'h00;
            us_next     = 20'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pps_meta_reg <= 1'b0;
            pps_sync_reg <= 1'b0;
            pps_prev_reg <= 1'b0;
            cnt_reg      <= '0;
            lock_reg     <= 1'b0;
            have_reg     <= 1'b0;
            nmea_reg     <= '0;
            time_reg     <= {`LPTS_PRESET_YEAR, `LPTS_PRESET_MONTH,
                             `LPTS_PRESET_DAY, 24'h000000};
            us_div_reg   <= 8'h00;
            us_reg       <= 20'h0;
        end else if (clk_en) begin
            pps_meta_reg <= pps_pin;
            pps_sync_reg <= pps_meta_reg;
            pps_prev_reg <= pps_sync_reg;
            cnt_reg      <= cnt_next;
            lock_reg     <= lock_next;
            have_reg     <= have_next;
            nmea_reg     <= nmea_next;
            time_reg     <= time_next;
            us_div_reg   <= us_div_next;
            us_reg       <= us_next;
        end
    end

    // ------------------------------------------------------------
    // packet framer
    // ------------------------------------------------------------
    lpts_state_e        state_reg, state_next;
    logic [9:0]         idx_reg,   idx_next;
    logic               gps_pend_reg, gps_pend_next;
    logic               pc_pend_reg,  pc_pend_next;
    logic               seq_on_reg,   seq_on_next;
    logic [23:0]        seq_reg,      seq_next;
    lpts_pkg::lpts_dt_s snap_t_reg,   snap_t_next;
    logic [19:0]        snap_us_reg,  snap_us_next;
    logic [7:0]         snap_rm_reg,  snap_rm_next;
    logic [23:0]        snap_seq_reg, snap_seq_next;
    logic [15:0]        ident_reg,    ident_next;
    logic [335:0]       hdr;
    logic [143:0]       gps_time;
    logic [127:0]       pc_tail;
    logic [7:0]         byte_val;
    logic [9:0]         last_idx;
    logic               beat_valid;
    logic               fifo_ready;
    lpts_pkg::lpts_beat_s beat;

    always_comb begin
        hdr = {`LPTS_BCAST_MAC, SRC_MAC, `LPTS_ETH_TYPE,
               `LPTS_IP_VER_LEN, `LPTS_IP_TOT_LEN, ident_reg,
               `LPTS_IP_FLAGS, `LPTS_IP_TTL, `LPTS_IP_PROTO,
               16'h0000, `LPTS_SRC_IP, `LPTS_BCAST_IP,
               `LPTS_UDP_SRC, `LPTS_UDP_DST,
               `LPTS_UDP_LEN, 16'h0000};
        gps_time = {`LPTS_GPS_SOP,
                    ascii_pair(snap_t_reg.year),
                    ascii_pair(snap_t_reg.month),
                    ascii_pair(snap_t_reg.day),
                    ascii_pair(snap_t_reg.second),
                    ascii_pair(snap_t_reg.minute),
                    ascii_pair(snap_t_reg.hour),
                    snap_us_reg[7:0], snap_us_reg[15:8],
                    {4'h0, snap_us_reg[19:16]}, 8'h00};
        pc_tail = {{7'h00, seq_on_reg},
                   snap_rm_reg, snap_t_reg,
                   snap_us_reg[7:0], snap_us_reg[15:8],
                   {4'h0, snap_us_reg[19:16]}, 8'h00,
                   snap_seq_reg[7:0], snap_seq_reg[15:8],
                   snap_seq_reg[23:16], 8'h00};
        byte_val = 8'h00;
        last_idx = 10'(`LPTS_PC_BYTES - 1);
        if (state_reg == ST_PC) begin
            byte_val = pc_tail[8*(15 - 32'(idx_reg[3:0])) +: 8];
            if (seq_on_reg) begin
                last_idx = 10'(`LPTS_PC_SEQ_BYTES - 1);
            end
        end else begin
            last_idx = 10'(`LPTS_GPS_BYTES - 1);
            if (idx_reg < 10'(`LPTS_HDR_BYTES)) begin
                byte_val = hdr[8*(`LPTS_HDR_BYTES - 1 - 32'(idx_reg)) +: 8];
            end else if (idx_reg < 10'(`LPTS_TIME_END)) begin
                byte_val = gps_time[8*(`LPTS_TIME_END - 1
                                       - 32'(idx_reg)) +: 8];
            end else if (idx_reg < 10'(`LPTS_NMEA_END)) begin
                byte_val = 8'h00;
            end else if (idx_reg < 10'(`LPTS_RSVD_END)) begin
                byte_val = `LPTS_FILL_BYTE;
            end else if (idx_reg == 10'(`LPTS_RSVD_END)) begin
                byte_val = nmea_fix_status;
            end else if (idx_reg == 10'(`LPTS_RSVD_END + 1)) begin
                byte_val = {7'h00, lock_reg};
            end
        end
        beat.data = byte_val;
        beat.last = idx_reg == last_idx;
        beat.gps  = state_reg == ST_GPS;
        beat_valid = state_reg != ST_IDLE;

        // a request landing on the start cycle is kept, not lost
        gps_pend_next = tick || gps_pend_reg;
        pc_pend_next  = pc_req || pc_pend_reg;
        state_next    = state_reg;
        idx_next      = idx_reg;
        seq_on_next   = seq_on_reg;
        seq_next      = seq_reg;
        snap_t_next   = snap_t_reg;
        snap_us_next  = snap_us_reg;
        snap_rm_next  = snap_rm_reg;
        snap_seq_next = snap_seq_reg;
        ident_next    = ident_reg;
        unique case (state_reg)
            ST_IDLE: begin
                snap_t_next  = time_reg;
                snap_us_next = us_reg;
                idx_next     = 10'h000;
                // gps packets win so the one-per-second cadence holds
                if (gps_pend_reg) begin
                    state_next    = ST_GPS;
                    gps_pend_next = tick;
                    ident_next    = ident_reg + 16'h0001;
                end else if (pc_pend_reg) begin
                    state_next    = ST_PC;
                    pc_pend_next  = pc_req;
                    snap_rm_next  = ret_code(ret_mode);
                    seq_on_next   = seq_enable;
                    snap_seq_next = seq_reg;
                    if (seq_enable) begin
                        seq_next = (seq_reg == `LPTS_SEQ_MAX) ? 24'h000000
                                 : seq_reg + 24'h000001;
                    end
                end
            end
            ST_PC, ST_GPS: begin
                if (fifo_ready) begin
                    idx_next = idx_reg + 10'h001;
                    if (beat.last) begin
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            idx_reg      <= 10'h000;
            gps_pend_reg <= 1'b0;
            pc_pend_reg  <= 1'b0;
            seq_on_reg   <= 1'b0;
            seq_reg      <= 24'h000000;
            snap_t_reg   <= '0;
            snap_us_reg  <= 20'h0;
            snap_rm_reg  <= 8'h00;
            snap_seq_reg <= 24'h000000;
            ident_reg    <= 16'h0000;
        end else if (clk_en) begin
            state_reg    <= state_next;
            idx_reg      <= idx_next;
            gps_pend_reg <= gps_pend_next;
            pc_pend_reg  <= pc_pend_next;
            seq_on_reg   <= seq_on_next;
            seq_reg      <= seq_next;
            snap_t_reg   <= snap_t_next;
            snap_us_reg  <= snap_us_next;
            snap_rm_reg  <= snap_rm_next;
            snap_seq_reg <= snap_seq_next;
            ident_reg    <= ident_next;
        end
    end

    // ------------------------------------------------------------
    // output buffer and status
    // ------------------------------------------------------------
    lpts_fifo #(
        .W     ($bits(lpts_pkg::lpts_beat_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .clk_en    (clk_en),
        .in_valid  (beat_valid),
        .in_ready  (fifo_ready),
        .in_data   (beat),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_beat)
    );

    assign pc_busy       = pc_pend_reg || state_reg == ST_PC;
    assign seq_flag_byte = {7'h00, seq_on_reg};
    assign pps_locked    = lock_reg;
    assign tick_pulse    = tick && clk_en;
    assign cur_time      = time_reg;
endmodule : lpts_stamper

`default_nettype wire

// File: pkg/lpts_defs.svh
`ifndef LPTS_DEFS_SVH
`define LPTS_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LPTS_CLK_NS        4
`define LPTS_TICK_NS       1000000000
`define LPTS_US_NS         1000
`define LPTS_TICK_CYCLES   (`LPTS_TICK_NS / `LPTS_CLK_NS)
`define LPTS_US_CYCLES     (`LPTS_US_NS / `LPTS_CLK_NS)
`define LPTS_US_MAX        20'd1000000

// ----------------------------------------------------------------
// return mode codes
// ----------------------------------------------------------------
`define LPTS_RM_FIRST      8'h33
`define LPTS_RM_STRONG     8'h37
`define LPTS_RM_LAST       8'h38
`define LPTS_RM_LAST_STR   8'h39
`define LPTS_RM_LAST_FST   8'h3b
`define LPTS_RM_FST_STR    8'h3c

// ----------------------------------------------------------------
// date-time preset and sequence limit
// ----------------------------------------------------------------
`define LPTS_PRESET_YEAR   8'd20
`define LPTS_PRESET_MONTH  8'd5
`define LPTS_PRESET_DAY    8'd20
`define LPTS_SEQ_MAX       24'hffffff

// ----------------------------------------------------------------
// gps packet and point-cloud tail framing
// ----------------------------------------------------------------
`define LPTS_SRC_IP        32'hc0a801c9
`define LPTS_BCAST_IP      32'hffffffff
`define LPTS_BCAST_MAC     48'hffffffffffff
`define LPTS_ETH_TYPE      16'h0800
`define LPTS_IP_VER_LEN    16'h4500
`define LPTS_IP_TOT_LEN    16'h021c
`define LPTS_IP_FLAGS      16'h4000
`define LPTS_IP_TTL        8'd64
`define LPTS_IP_PROTO      8'd17
`define LPTS_UDP_SRC       16'h2710
`define LPTS_UDP_DST       16'h277e
`define LPTS_UDP_LEN       16'h0208
`define LPTS_GPS_SOP       16'hffee
`define LPTS_HDR_BYTES     42
`define LPTS_TIME_END      60
`define LPTS_NMEA_END      160
`define LPTS_RSVD_END      548
`define LPTS_GPS_BYTES     554
`define LPTS_FILL_BYTE     8'hdf
`define LPTS_PC_BYTES      12
`define LPTS_PC_SEQ_BYTES  16

`endif

// File: pkg/lpts_pkg.sv
package lpts_pkg;

    typedef enum logic [2:0] {
        RET_FIRST,
        RET_STRONGEST,
        RET_LAST,
        RET_LAST_STRONGEST,
        RET_LAST_FIRST,
        RET_FIRST_STRONGEST
    } lpts_ret_e;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } lpts_dt_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       gps;
    } lpts_beat_s;

endpackage : lpts_pkg

// File: verification/lpts_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// stamper checks
// ----------
module lpts_checker (
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst,
    // status and stream
    input wire logic [7:0]           seq_flag_byte,
    input wire logic                 pps_locked,
    input wire logic                 tick_pulse,
    input wire lpts_pkg::lpts_dt_s   cur_time,
    input wire logic                 out_valid,
    input wire logic                 out_ready,
    input wire lpts_pkg::lpts_beat_s out_beat
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_time: assert property (
        $fell(rst) |-> cur_time == 48'h140514000000)
        else $error("time not preset after reset");
    a_tick_moves: assert property (
        tick_pulse |=> cur_time != $past(cur_time))
        else $error("time did not advance on tick");
    a_time_hold: assert property (
        !tick_pulse |=> $stable(cur_time))
        else $error("time changed without tick");
    a_gps_follows: assert property (
        tick_pulse |-> ##[1:1000] (out_valid && out_beat.gps))
        else $error("no gps packet after tick");
    a_seq_rsvd: assert property (
        seq_flag_byte[7:1] == 7'h0)
        else $error("seq flag reserved bits set");
    a_beat_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_beat))
        else $error("beat changed while stalled");
    a_lock_on_tick: assert property (
        $rose(pps_locked) |-> $past(tick_pulse))
        else $error("lock without tick");
    a_lost_unlock: assert property (
        $fell(pps_locked) |-> $past(tick_pulse))
        else $error("unlock without tick");
    cover property (tick_pulse);
    cover property ($rose(pps_locked));
    cover property (out_valid && out_ready && out_beat.last && !out_beat.gps);
endmodule : lpts_checker
bind lpts_stamper lpts_checker lpts_checker_inst (
    .core_clk(core_clk), .rst(rst), .seq_flag_byte(seq_flag_byte),
    .pps_locked(pps_locked), .tick_pulse(tick_pulse), .cur_time(cur_time),
    .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));
`default_nettype wire

// File: verification/lpts_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// broadcast host sink
// ----------
module lpts_host_model (
    input wire logic                 core_clk,
    input wire logic                 slow,
    input wire logic                 out_valid,
    output logic                     out_ready,
    input wire lpts_pkg::lpts_beat_s out_beat,
    output logic [7:0]               gps_pkt [0:599],
    output logic [7:0]               tail_pkt [0:15],
    output int                       n_gps,
    output int                       n_tail,
    output int                       tail_len
);
    int         idx;
    logic [1:0] ph;
    initial begin
        idx = 0; ph = 2'h0; n_gps = 0; n_tail = 0; tail_len = 0;
    end
    // a slow host refuses one beat in four, so the fifo fills
    assign out_ready = !(slow && ph == 2'h3);
    always @(posedge core_clk) begin
        ph <= ph + 2'h1;
        if (out_valid && out_ready) begin
            if (out_beat.gps) gps_pkt[idx] <= out_beat.data;
            else tail_pkt[idx[3:0]] <= out_beat.data;
            idx <= out_beat.last ? 0 : idx + 1;
            if (out_beat.last && out_beat.gps) n_gps <= n_gps + 1;
            if (out_beat.last && !out_beat.gps) n_tail <= n_tail + 1;
            if (out_beat.last && !out_beat.gps) tail_len <= idx + 1;
        end
    end
endmodule : lpts_host_model
`default_nettype wire

// File: verification/tb_lpts_stamper.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// bench
// ----------
module tb_lpts_stamper;
    logic                 core_clk, rst, pps_pin, nmea_valid, pc_req, seq_enable;
    logic                 slow, pps_locked, tick_pulse, out_valid, out_ready;
    logic [7:0]           seq_flag_byte, gps_pkt [0:599], tail_pkt [0:15];
    lpts_pkg::lpts_dt_s   nmea_time, cur_time;
    lpts_pkg::lpts_ret_e  ret_mode;
    lpts_pkg::lpts_beat_s out_beat;
    int                   n_gps, n_tail, tail_len, fails, samples_checked;
    lpts_stamper #(.TICK_CYCLES(2000), .LOST_CYCLES(3000)) lpts_stamper_inst (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .pps_pin(pps_pin),
        .nmea_valid(nmea_valid), .nmea_time(nmea_time), .nmea_fix_status(8'h41),
        .pc_req(pc_req), .ret_mode(ret_mode), .seq_enable(seq_enable), .pc_busy(),
        .seq_flag_byte(seq_flag_byte), .pps_locked(pps_locked), .tick_pulse(tick_pulse),
        .cur_time(cur_time), .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));
    lpts_host_model lpts_host_model_inst (.core_clk(core_clk), .slow(slow),
        .out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat), .gps_pkt(gps_pkt),
        .tail_pkt(tail_pkt), .n_gps(n_gps), .n_tail(n_tail), .tail_len(tail_len));
    task automatic check(input string what, input logic [47:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        if (fails == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic wait_cnt(ref int cnt, input int old);
        for (int k = 0; k < 4000 && cnt == old; k++) @(negedge core_clk);
        if (cnt == old) begin
            fails++;
            summarize();
        end
    endtask : wait_cnt
    task automatic pps_pulse();
        pps_pin = 1'b1;
        repeat (10) @(negedge core_clk);
        pps_pin = 1'b0;
    endtask : pps_pulse
    task automatic t_tails();
        int s, n;
        logic [31:0] us;
        logic [7:0] codes [6] = '{8'h33, 8'h37, 8'h38, 8'h39, 8'h3b, 8'h3c};
        s = 0;
        for (int i = 0; i < 6; i++) begin
            n = n_tail;
            ret_mode = lpts_pkg::lpts_ret_e'(i);
            seq_enable = i[0];
            pc_req = 1'b1;
            @(negedge core_clk);
            pc_req = 1'b0;
            wait_cnt(n_tail, n);
            check("mode", tail_pkt[1], codes[i]);
            check("flag", tail_pkt[0], {7'h0, i[0]});
            check("time", {tail_pkt[2], tail_pkt[3], tail_pkt[4], tail_pkt[5], tail_pkt[6], tail_pkt[7]}, 48'h140514000000);
            // no tick yet and under 250 cycles since reset: still 0 us
            us = {tail_pkt[11], tail_pkt[10], tail_pkt[9], tail_pkt[8]};
            check("us", us, 48'h0);
            check("len", tail_len, i[0] ? 16 : 12);
            if (i[0]) begin
                us = {tail_pkt[15], tail_pkt[14], tail_pkt[13], tail_pkt[12]};
                check("seq", us, s);
                s++;
            end
        end
    endtask : t_tails
    task automatic t_gps();
        int gi [23] = '{0, 5, 12, 13, 14, 22, 23, 26, 29, 30, 33, 35, 37,
            39, 42, 43, 44, 46, 548, 549, 20, 50, 54};
        logic [7:0] gv [23] = '{8'hff, 8'hff, 8'h08, 8'h00, 8'h45, 8'h40,
            8'h11, 8'hc0, 8'hc9, 8'hff, 8'hff, 8'h10, 8'h7e, 8'h08, 8'hff,
            8'hee, 8'h30, 8'h35, 8'h41, 8'h00, 8'h40, 8'h31, 8'h30};
        wait_cnt(n_gps, 0);
        for (int i = 0; i < 23; i++) check("gps byte", gps_pkt[gi[i]], gv[i]);
    endtask : t_gps
    task automatic t_pps();
        pps_pulse();
        check("locked", pps_locked, 48'h1);
        nmea_time = 48'h7c061e0c223a;
        nmea_valid = 1'b1;
        @(negedge core_clk);
        nmea_valid = 1'b0;
        repeat (1500) @(negedge core_clk);
        check("gps count", n_gps, 48'h2);
        check("lock byte", gps_pkt[549], 48'h1);
        pps_pulse();
        check("nmea time", cur_time, 48'h7c061e0c223b);
        // no pulse for longer than the loss limit
        repeat (3100) @(negedge core_clk);
        check("unlocked", pps_locked, 48'h0);
        check("own time", cur_time, 48'h7c061e0c2300);
    endtask : t_pps
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        fails = 0; samples_checked = 0; rst = 1'b1; pps_pin = 1'b0; nmea_valid = 1'b0;
        nmea_time = '0; pc_req = 1'b0; seq_enable = 1'b0; ret_mode = lpts_pkg::RET_FIRST; slow = 1'b0;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        check("reset time", cur_time, 48'h140514000000);
        t_tails();
        slow = 1'b1;
        t_gps();
        t_pps();
        summarize();
    end
endmodule : tb_lpts_stamper
`default_nettype wire
